//--- rtl/pamux_pkg.sv
`default_nettype none
package pamux_pkg;

  // ==========================================================
  // Register byte offsets (one aligned 32-bit word each)
  // ==========================================================
  localparam logic [7:0] PAMUX_PORT_LATCH_OFS = 8'h00;
  localparam logic [7:0] PAMUX_DIRECTION_OFS = 8'h04;
  localparam logic [7:0] PAMUX_PORT_MODE_OFS = 8'h08;
  localparam logic [7:0] PAMUX_FUNC_SEL_OFS = 8'h0C;
  localparam logic [7:0] PAMUX_FUNC_EXT_OFS = 8'h10;
  localparam logic [7:0] PAMUX_RISE_SEL_OFS = 8'h14;
  localparam logic [7:0] PAMUX_FALL_SEL_OFS = 8'h18;
  localparam logic [7:0] PAMUX_PIN_READ_OFS = 8'h1C;
  localparam logic [7:0] PAMUX_IN_PORT_OFS = 8'h20;
  localparam logic [7:0] PAMUX_INT_STATUS_OFS = 8'h24;
  localparam logic [7:0] PAMUX_INT_MASK_OFS = 8'h28;

  // ==========================================================
  // Pin positions within the three-pin group
  // ==========================================================
  localparam int PAMUX_NPINS = 3;
  localparam int PAMUX_PIN_SOUT = 0;
  localparam int PAMUX_PIN_SCK = 1;
  localparam int PAMUX_PIN_SIN = 2;

  // ==========================================================
  // Reset values
  // ==========================================================
  localparam logic [2:0] PAMUX_LATCH_RST = 3'h0;
  localparam logic [2:0] PAMUX_DIR_RST = 3'h7;
  localparam logic [2:0] PAMUX_MODE_RST = 3'h0;
  localparam logic [2:0] PAMUX_FSEL_RST = 3'h0;
  localparam logic [2:0] PAMUX_FEXT_RST = 3'h0;
  localparam logic PAMUX_EDGE_RST = 1'b0;
  localparam logic PAMUX_STAT_RST = 1'b0;
  localparam logic PAMUX_MASK_RST = 1'b0;

  // Pin drive towards the pads
  typedef struct packed {
    logic [PAMUX_NPINS-1:0] out;
    logic [PAMUX_NPINS-1:0] oe;
  } pamux_pin_drv_s;

  // Signals from on-chip peripherals to the mux
  typedef struct packed {
    logic serial_out;
    logic uart_tx;
    logic serial_clk_out;
    logic serial_master;
    logic chip_select;
  } pamux_periph_out_s;

  // Signals from the mux to on-chip peripherals
  typedef struct packed {
    logic serial_clk_in;
    logic serial_in;
    logic uart_rx;
    logic ext_irq;
  } pamux_periph_in_s;

endpackage : pamux_pkg
`default_nettype wire

//--- rtl/pamux_port.sv
// Functional notes
// - Analog-shared port is input only, 4/8 pins
// - Those pins feed converter channels, no pull-up
// - Serial clock pin drives only as master
// - Interrupt pin only feeds edge detector
`default_nettype none
module pamux_port #(
  parameter int IN_WIDTH = 8
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Three multiplexed pins
  input wire logic [pamux_pkg::PAMUX_NPINS-1:0] pin_in,
  output pamux_pkg::pamux_pin_drv_s pin_drv,
  // Input-only analog-shared port
  input wire logic [IN_WIDTH-1:0] input_only_port,
  output logic [IN_WIDTH-1:0] analog_input_channel,
  // Peripheral side
  input wire pamux_pkg::pamux_periph_out_s periph_out,
  output pamux_pkg::pamux_periph_in_s periph_in,
  // Interrupt
  output logic irq
);
  import pamux_pkg::*;

  // ==========================================================
  // Elaboration check
  // ==========================================================
  if (!(IN_WIDTH == 4 || IN_WIDTH == 8)) begin : g_bad_width
    $error("IN_WIDTH must be 4 or 8");
  end

  // ==========================================================
  // State
  // ==========================================================
  logic [2:0] port_latch;             // Output latch
  logic [2:0] pin_direction_bit;      // 1 = input, 0 = output
  logic [2:0] port_mode_select_reg;   // 1 = alternate function
  logic [2:0] function_select_reg;
  logic [2:0] function_select_ext_reg;
  logic rising_edge_select_reg;       // Edge enables of the interrupt pin
  logic falling_edge_select_reg;
  logic int_status;                   // Sticky edge event
  logic int_mask;                     // 1 = event reaches irq
  logic [2:0] pin_meta;               // First sync stage, read only by pin_sync
  logic [2:0] pin_sync;
  logic [IN_WIDTH-1:0] in_meta;
  logic [IN_WIDTH-1:0] in_sync;
  logic intp_prev;                    // Last sampled interrupt pin level

  logic [2:0] next_port_latch;
  logic [2:0] next_direction;
  logic [2:0] next_mode;
  logic [2:0] next_fsel;
  logic [2:0] next_fext;
  logic next_rise;
  logic next_fall;
  logic next_int_status;
  logic next_int_mask;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  logic next_irq;
  pamux_pin_drv_s next_pin_drv;
  pamux_periph_in_s next_periph_in;
  logic [IN_WIDTH-1:0] next_analog;

  // Read value of one pin: latch when driving, level when sensing
  function automatic logic pin_read(input logic latch, input logic dir, input logic lvl);
    pin_read = dir ? lvl : latch;
  endfunction : pin_read

  // Pin selected as interrupt input: mode 1, ext 0, select 1
  logic intp_sel;
  logic edge_evt;
  assign intp_sel = port_mode_select_reg[PAMUX_PIN_SCK] &
                    !function_select_ext_reg[PAMUX_PIN_SCK] &
                    function_select_reg[PAMUX_PIN_SCK];
  // Edge detector only sees the pin while it is an interrupt input;
  // software is expected to clear the edge enables across mode changes
  assign edge_evt = intp_sel &
                    ((rising_edge_select_reg & pin_sync[PAMUX_PIN_SCK] & !intp_prev) |
                     (falling_edge_select_reg & !pin_sync[PAMUX_PIN_SCK] & intp_prev));

  // ==========================================================
  // Register file and APB: next values
  // ==========================================================
  // Zero-wait slave: pready is raised for the access phase
  always_comb begin
    logic wr;
    logic [2:0] rd_pins;
    wr = psel & penable & pready & pwrite;
    rd_pins = 3'h0;
    next_port_latch = port_latch;
    next_direction = pin_direction_bit;
    next_mode = port_mode_select_reg;
    next_fsel = function_select_reg;
    next_fext = function_select_ext_reg;
    next_rise = rising_edge_select_reg;
    next_fall = falling_edge_select_reg;
    next_int_mask = int_mask;
    next_int_status = int_status;
    next_pready = psel & !penable;
    next_pslverr = 1'b0;
    next_prdata = 32'h0000_0000;
    for (int i = 0; i < PAMUX_NPINS; i++) begin
      rd_pins[i] = pin_read(port_latch[i], pin_direction_bit[i], pin_sync[i]);
    end
    // Setup phase: decode address and prepare the answer
    if (psel & !penable) begin
      unique case (paddr)
        PAMUX_PORT_LATCH_OFS: next_prdata[2:0] = port_latch;
        PAMUX_DIRECTION_OFS: next_prdata[2:0] = pin_direction_bit;
        PAMUX_PORT_MODE_OFS: next_prdata[2:0] = port_mode_select_reg;
        PAMUX_FUNC_SEL_OFS: next_prdata[2:0] = function_select_reg;
        PAMUX_FUNC_EXT_OFS: next_prdata[2:0] = function_select_ext_reg;
        PAMUX_RISE_SEL_OFS: next_prdata[0] = rising_edge_select_reg;
        PAMUX_FALL_SEL_OFS: next_prdata[0] = falling_edge_select_reg;
        PAMUX_PIN_READ_OFS: next_prdata[2:0] = rd_pins;
        PAMUX_IN_PORT_OFS: next_prdata[IN_WIDTH-1:0] = in_sync;
        PAMUX_INT_STATUS_OFS: next_prdata[0] = int_status;
        PAMUX_INT_MASK_OFS: next_prdata[0] = int_mask;
        default: next_pslverr = 1'b1;
      endcase
    end
    // Access phase: writes land at the pready edge
    if (wr) begin
      unique case (paddr)
        PAMUX_PORT_LATCH_OFS: next_port_latch = pwdata[2:0];
        PAMUX_DIRECTION_OFS: next_direction = pwdata[2:0];
        PAMUX_PORT_MODE_OFS: next_mode = pwdata[2:0];
        PAMUX_FUNC_SEL_OFS: next_fsel = pwdata[2:0];
        PAMUX_FUNC_EXT_OFS: next_fext = pwdata[2:0];
        PAMUX_RISE_SEL_OFS: next_rise = pwdata[0];
        PAMUX_FALL_SEL_OFS: next_fall = pwdata[0];
        PAMUX_INT_STATUS_OFS: next_int_status = int_status & !pwdata[0];
        PAMUX_INT_MASK_OFS: next_int_mask = pwdata[0];
        // Input port and pin read are read-only; no pull-up register exists
        default: next_int_mask = int_mask;
      endcase
    end
    // A new edge wins over a clear in the same cycle
    if (edge_evt) begin
      next_int_status = 1'b1;
    end
    next_irq = next_int_status & next_int_mask;
  end

  // ==========================================================
  // Register file and APB: registers
  // ==========================================================
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      port_latch <= PAMUX_LATCH_RST;
      pin_direction_bit <= PAMUX_DIR_RST;
      port_mode_select_reg <= PAMUX_MODE_RST;
      function_select_reg <= PAMUX_FSEL_RST;
      function_select_ext_reg <= PAMUX_FEXT_RST;
      rising_edge_select_reg <= PAMUX_EDGE_RST;
      falling_edge_select_reg <= PAMUX_EDGE_RST;
      int_status <= PAMUX_STAT_RST;
      int_mask <= PAMUX_MASK_RST;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      irq <= 1'b0;
    end else begin
      port_latch <= next_port_latch;
      pin_direction_bit <= next_direction;
      port_mode_select_reg <= next_mode;
      function_select_reg <= next_fsel;
      function_select_ext_reg <= next_fext;
      rising_edge_select_reg <= next_rise;
      falling_edge_select_reg <= next_fall;
      int_status <= next_int_status;
      int_mask <= next_int_mask;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
      irq <= next_irq;
    end
  end

  // ==========================================================
  // Pin multiplexer: next values
  // ==========================================================
  // Mode gates every alternate path, so a half-written select only
  // matters while mode is already 1; software writes selects first
  always_comb begin
    logic [2:0] m;
    logic [2:0] f;
    logic [2:0] e;
    m = port_mode_select_reg;
    f = function_select_reg;
    e = function_select_ext_reg;
    // Plain port by default: latch driven when direction is output
    next_pin_drv.out = port_latch;
    next_pin_drv.oe = ~pin_direction_bit;
    // Serial out / uart transmit pin
    if (m[PAMUX_PIN_SOUT]) begin
      next_pin_drv.out[PAMUX_PIN_SOUT] = f[PAMUX_PIN_SOUT] ? periph_out.uart_tx
                                                           : periph_out.serial_out;
    end
    // Serial clock / interrupt / chip select pin
    if (m[PAMUX_PIN_SCK]) begin
      unique case ({e[PAMUX_PIN_SCK], f[PAMUX_PIN_SCK]})
        2'b00: begin
          next_pin_drv.out[PAMUX_PIN_SCK] = periph_out.serial_clk_out;
          next_pin_drv.oe[PAMUX_PIN_SCK] = periph_out.serial_master;
        end
        2'b01: begin
          next_pin_drv.oe[PAMUX_PIN_SCK] = 1'b0;
        end
        2'b10: begin
          next_pin_drv.out[PAMUX_PIN_SCK] = periph_out.chip_select;
        end
        default: begin
          next_pin_drv.oe[PAMUX_PIN_SCK] = 1'b0;
        end
      endcase
    end
    // Serial in / uart receive pin is input only in alternate mode
    if (m[PAMUX_PIN_SIN]) begin
      next_pin_drv.oe[PAMUX_PIN_SIN] = 1'b0;
    end
    // Inputs reach a peripheral only when its function is selected
    next_periph_in.serial_clk_in = m[PAMUX_PIN_SCK] & !e[PAMUX_PIN_SCK] &
                                   !f[PAMUX_PIN_SCK] & pin_sync[PAMUX_PIN_SCK];
    next_periph_in.serial_in = m[PAMUX_PIN_SIN] & !f[PAMUX_PIN_SIN] & pin_sync[PAMUX_PIN_SIN];
    next_periph_in.uart_rx = m[PAMUX_PIN_SIN] & f[PAMUX_PIN_SIN] & pin_sync[PAMUX_PIN_SIN];
    next_periph_in.ext_irq = edge_evt;
    // Analog-shared port never drives; levels pass on to the converter
    next_analog = in_sync;
  end

  // ==========================================================
  // Pin multiplexer: registers and synchronisers
  // ==========================================================
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_meta <= 3'h0;
      pin_sync <= 3'h0;
      in_meta <= '0;
      in_sync <= '0;
      intp_prev <= 1'b0;
      pin_drv <= '0;
      periph_in <= '0;
      analog_input_channel <= '0;
    end else begin
      pin_meta <= pin_in;
      pin_sync <= pin_meta;
      in_meta <= input_only_port;
      in_sync <= in_meta;
      intp_prev <= pin_sync[PAMUX_PIN_SCK];
      pin_drv <= next_pin_drv;
      periph_in <= next_periph_in;
      analog_input_channel <= next_analog;
    end
  end

endmodule : pamux_port
`default_nettype wire

//--- sim/pamux_port_sva.sv
`default_nettype none
module pamux_port_chk #(
  parameter int IN_WIDTH = 8
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic reset_n,
  // Bus handshake
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // Pins and ports
  input wire logic [pamux_pkg::PAMUX_NPINS-1:0] pin_in,
  input wire pamux_pkg::pamux_pin_drv_s pin_drv,
  input wire logic [IN_WIDTH-1:0] input_only_port,
  input wire logic [IN_WIDTH-1:0] analog_input_channel,
  input wire pamux_pkg::pamux_periph_in_s periph_in
);
  import pamux_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // Setup phase, then an edge on the shared pin three edges back
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_pad_edge;
    $past(pin_in[1], 3) != $past(pin_in[1], 4);
  endsequence
  a_ready_after_setup: assert property (s_setup |=> pready)
    else $error("ready missing after setup");
  a_ready_single: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_analog_follows: assert property (analog_input_channel == $past(input_only_port, 3))
    else $error("analog channel lags wrongly");
  a_irq_pin_input: assert property (periph_in.ext_irq |-> !pin_drv.oe[1])
    else $error("interrupt pin is driven");
  a_irq_from_edge: assert property (periph_in.ext_irq |-> s_pad_edge)
    else $error("interrupt pulse without pad edge");
endmodule : pamux_port_chk

bind pamux_port pamux_port_chk #(.IN_WIDTH(IN_WIDTH)) u_chk (.ref_clk(ref_clk),
  .reset_n(reset_n), .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
  .pin_in(pin_in), .pin_drv(pin_drv), .input_only_port(input_only_port),
  .analog_input_channel(analog_input_channel), .periph_in(periph_in));
`default_nettype wire

//--- sim/pamux_pads.sv
`default_nettype none
module pamux_pads (
  // Clock
  input wire logic ref_clk,
  // Drive from the mux and far-side levels
  input wire pamux_pkg::pamux_pin_drv_s pin_drv,
  input wire logic [2:0] ext_lvl,
  input wire logic master,
  // Resolved pads and peripheral outputs
  output logic [2:0] pin_in,
  output pamux_pkg::pamux_periph_out_s periph_out
);
  import pamux_pkg::*;
  // Free-running pattern so every peripheral output except serial_master keeps toggling
  logic [3:0] cnt = 4'h0;
  always_ff @(posedge ref_clk) begin
    cnt <= cnt + 4'h1;
  end
  // Pad wins for the mux when it drives, else the far device holds it
  assign pin_in = (pin_drv.oe & pin_drv.out) | (~pin_drv.oe & ext_lvl);
  assign periph_out = '{cnt[0], cnt[1], cnt[2], master, cnt[3]};
endmodule : pamux_pads
`default_nettype wire

//--- sim/port_alt_function_mux_tb.sv
`default_nettype none
module port_alt_function_mux_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import pamux_pkg::*;
  logic ref_clk, reset_n, psel, penable, pwrite, pready, pslverr, irq, master, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0] pin_in, ext_lvl, lat, dir, mode;
  logic [3:0] in_port, ana;
  pamux_pin_drv_s pin_drv;
  pamux_periph_out_s periph_out;
  pamux_periph_in_s periph_in;
  int failures, checks, seed, i;
  // ==========================================
  // Design and far side
  pamux_port #(.IN_WIDTH(4)) dut (.ref_clk(ref_clk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pin_in(pin_in), .pin_drv(pin_drv),
    .input_only_port(in_port), .analog_input_channel(ana), .periph_out(periph_out),
    .periph_in(periph_in), .irq(irq));
  pamux_pads u_pads (.ref_clk(ref_clk), .pin_drv(pin_drv), .ext_lvl(ext_lvl),
    .master(master), .pin_in(pin_in), .periph_out(periph_out));
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  // ==========================================
  // Tasks
  task automatic print_verdict();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : print_verdict
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s exp %h got %h", what, exp, got);
    end
  endtask : chk
  // One transfer; ready and data are taken at the edge that shows ready
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      failures++;
      print_verdict();
    end else begin
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // Let one edge pass so the next call never re-drives psel in this step
      @(posedge ref_clk);
    end
  endtask : apb
  task automatic rchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(what, exp, rd);
  endtask : rchk
  task automatic edge_to(input logic lvl, input logic [31:0] st);
    ext_lvl[1] <= lvl;
    repeat (6) @(posedge ref_clk);
    rchk("status", PAMUX_INT_STATUS_OFS, st);
  endtask : edge_to
  // ==========================================
  // Main sequence
  initial begin
    {reset_n, psel, penable, pwrite, master, paddr, pwdata, ext_lvl, in_port} = '0;
    {failures, checks} = '0;
    seed = 83;
    repeat (12) @(posedge ref_clk);
    reset_n <= 1'b1;
    @(posedge ref_clk);
    rchk("dir rst", PAMUX_DIRECTION_OFS, {29'h0, PAMUX_DIR_RST});
    rchk("mode rst", PAMUX_PORT_MODE_OFS, 32'h0000_0000);
    apb(1'b0, 8'h3C, 32'h0000_0000);
    chk("slverr", 32'h1, {31'h0, err});
    // Random latch, direction, mode and far-side levels
    for (i = 0; i < 10; i++) begin
      lat = 3'($random(seed));
      dir = 3'($random(seed));
      mode = 3'($random(seed));
      ext_lvl <= 3'($random(seed));
      in_port <= 4'($random(seed));
      apb(1'b1, PAMUX_PORT_LATCH_OFS, {29'h0, lat});
      apb(1'b1, PAMUX_DIRECTION_OFS, {29'h0, dir});
      apb(1'b1, PAMUX_PORT_MODE_OFS, {29'h0, mode});
      repeat (4) @(posedge ref_clk);
      rchk("pin read", PAMUX_PIN_READ_OFS, {29'h0, (dir & ext_lvl) | (~dir & lat)});
      rchk("in port", PAMUX_IN_PORT_OFS, {28'h0, in_port});
      chk("analog", {28'h0, in_port}, {28'h0, ana});
      chk("drv oe", {29'h0, ~dir & ~(mode & 3'b110)}, {29'h0, pin_drv.oe});
      chk("drv out", {29'h0, lat & (~mode | 3'b100)}, {29'h0, pin_drv.out & (~mode | 3'b100)});
      chk("periph in", {28'h0, mode[1] & ext_lvl[1], mode[2] & ext_lvl[2], 2'b00},
          {28'h0, periph_in});
    end
    // Serial clock pin follows master/slave
    ext_lvl <= 3'h0;
    apb(1'b1, PAMUX_PORT_MODE_OFS, 32'h0000_0002);
    for (i = 1; i >= 0; i--) begin
      master <= i[0];
      repeat (3) @(posedge ref_clk);
      chk("sck oe", {31'h0, i[0]}, {31'h0, pin_drv.oe[1]});
    end
    // Chip select on the shared pin, uart receive on the serial-in pin
    ext_lvl <= 3'h4;
    apb(1'b1, PAMUX_PORT_MODE_OFS, 32'h0000_0000);
    apb(1'b1, PAMUX_FUNC_EXT_OFS, 32'h0000_0002);
    apb(1'b1, PAMUX_FUNC_SEL_OFS, 32'h0000_0004);
    apb(1'b1, PAMUX_PORT_MODE_OFS, 32'h0000_0006);
    repeat (4) @(posedge ref_clk);
    chk("cs oe", {31'h0, ~dir[1]}, {31'h0, pin_drv.oe[1]});
    chk("uart rx", 32'h1, {31'h0, periph_in.uart_rx});
    apb(1'b1, PAMUX_PORT_MODE_OFS, 32'h0000_0000);
    apb(1'b1, PAMUX_FUNC_EXT_OFS, 32'h0000_0000);
    // Interrupt pin: edges off, select, then pick an edge
    apb(1'b1, PAMUX_PORT_MODE_OFS, 32'h0000_0000);
    apb(1'b1, PAMUX_FUNC_SEL_OFS, 32'h0000_0002);
    apb(1'b1, PAMUX_PORT_MODE_OFS, 32'h0000_0002);
    edge_to(1'b1, 32'h0);
    edge_to(1'b0, 32'h0);
    apb(1'b1, PAMUX_RISE_SEL_OFS, 32'h0000_0001);
    apb(1'b1, PAMUX_INT_MASK_OFS, 32'h0000_0001);
    edge_to(1'b1, 32'h1);
    chk("irq on", 32'h1, {31'h0, irq});
    chk("int oe", 32'h0, {31'h0, pin_drv.oe[1]});
    apb(1'b1, PAMUX_INT_STATUS_OFS, 32'h0000_0001);
    edge_to(1'b0, 32'h0);
    chk("irq off", 32'h0, {31'h0, irq});
    apb(1'b1, PAMUX_INT_MASK_OFS, 32'h0000_0000);
    edge_to(1'b1, 32'h1);
    chk("irq masked", 32'h0, {31'h0, irq});
    apb(1'b1, PAMUX_RISE_SEL_OFS, 32'h0000_0000);
    apb(1'b1, PAMUX_PORT_MODE_OFS, 32'h0000_0000);
    print_verdict();
  end
endmodule : port_alt_function_mux_tb
`default_nettype wire
